// >>> include/cmd_port_pkg.sv
// Purpose: constants for the serial register command port
// Assumes: byte-level receive and transmit ports, 7 data bits per byte
// Notes:
// How it works
// R1 - host writes address, write code, upper seven, lower seven, checksum
// R2 - checksum is command plus both data bytes, low seven bits
// R3 - read is address then read code; reply is upper, lower, checksum
// R4 - reply checksum is both data bytes plus read code, low seven bits
// R5 - seven bit node address, reset zero; only own frames acted on
// R6 - node address written by its own code from second data byte
// R7 - written node address kept in non-volatile store, restored at restart
// R8 - own node address transmitted right after system start
// R9 - baud select in bits 2 to 1, reset 00 meaning 19200
// R10 - bit 8 enables top speed and supply compensation
// R11 - bit 7 set ignores brake function of the brake input
// R12 - bit 6 selects pulse measurement resolution
// R13 - calibration write holds 14 bits, applied when saved
// R14 - calibration off by over twenty percent is discarded
// R15 - firmware and board revisions are read-only on own codes
// R16 - config two written by one code, read by another; one clears
// R17 - frame with wrong checksum dropped silently
// R18 - byte with bit 7 set starts a frame; rest have bit 7 clear
package cmd_port_pkg;
   localparam logic [6:0] WR_CONFIG_TWO = 7'h75;
   localparam logic [6:0] RD_CONFIG_TWO = 7'h35;
   localparam logic [6:0] WR_NODE_ADDRESS = 7'h7c;
   localparam logic [6:0] WR_CURRENT_CAL = 7'h7d;
   localparam logic [6:0] RD_FIRMWARE = 7'h3e;
   localparam logic [6:0] RD_BOARD = 7'h3f;
   localparam int CFG_TOP_COMP_BIT = 8;
   localparam int CFG_BRAKE_IGN_BIT = 7;
   localparam int CFG_PULSE_RES_BIT = 6;
   localparam int CFG_BAUD_LSB = 1;
   localparam int CFG_BAUD_MSB = 2;
   localparam logic [1:0] BAUD_19200 = 2'h0;
   localparam logic [6:0] NODE_ADDRESS_RESET = 7'h00;
   localparam logic [13:0] CONFIG_TWO_RESET = 14'h0100;
   localparam logic [13:0] CAL_RESET = 14'h0000;
   localparam int CAL_TOL_PCT = 20;
   localparam logic [16:0] CAL_TOL_DIV = 17'(100 / CAL_TOL_PCT);
   localparam logic [1:0] REPLY_BYTES = 2'h3;
   localparam logic [1:0] START_BYTES = 2'h1;

   typedef enum logic [2:0] {
      R_IDLE = 3'b000,
      R_CMD = 3'b001,
      R_D1 = 3'b010,
      R_D2 = 3'b011,
      R_SUM = 3'b100
   } rx_state_type;
endpackage

// >>> verilog/cmd_port.sv
// Purpose: serial command interpreter for registers of a motor controller
// Assumes: rx bytes arrive as one-cycle strobes; tx byte handshakes
// Notes: non-volatile store lives outside; its value is read at boot
`timescale 1ns/100ps
module cmd_port #(
   parameter logic [13:0] FIRMWARE_REV = 14'h0001,
   parameter logic [13:0] BOARD_REV = 14'h0001
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   input wire logic [6:0] nv_addr_in,
   output logic nv_addr_wr,
   output logic [6:0] node_addr,
   input wire logic [13:0] measured_current,
   input wire logic save_cal,
   output logic [13:0] cal_value,
   output logic comp_enable,
   output logic brake_ignore,
   output logic pulse_resolution_select,
   output logic [1:0] baud_select
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   cmd_port_pkg::rx_state_type st_q, st_d;
   logic boot_q;
   logic [6:0] addr_q;
   logic [6:0] cmd_q;
   logic [6:0] d1_q;
   logic [6:0] d2_q;
   logic [13:0] cfg_q;
   logic [13:0] cal_pend_q;
   logic [13:0] cal_q;
   logic nv_wr_q;
   logic tx_valid_q;
   logic [7:0] tx_byte_q;
   logic [15:0] tx_buf_q;
   logic [1:0] tx_cnt_q;

   // ------------------------------------------------------------
   // frame decode
   // ------------------------------------------------------------
   wire rx_start = rx_valid && rx_byte[7];
   wire rx_data = rx_valid && !rx_byte[7];
   wire addr_hit = rx_byte[6:0] == addr_q;
   wire [6:0] rx_cmd = rx_byte[6:0];
   wire is_write = rx_cmd == cmd_port_pkg::WR_CONFIG_TWO ||
                   rx_cmd == cmd_port_pkg::WR_NODE_ADDRESS ||
                   rx_cmd == cmd_port_pkg::WR_CURRENT_CAL;
   wire is_read = rx_cmd == cmd_port_pkg::RD_CONFIG_TWO ||
                  rx_cmd == cmd_port_pkg::RD_FIRMWARE ||
                  rx_cmd == cmd_port_pkg::RD_BOARD;
   wire tx_busy = tx_cnt_q != 2'h0;
   wire [6:0] sum_calc = 7'(cmd_q + d1_q + d2_q);
   // R2 checksum check
   wire sum_ok = sum_calc == rx_byte[6:0];
   // R17 only good frames commit
   wire wr_done = rx_data && st_q == cmd_port_pkg::R_SUM && sum_ok;
   wire [13:0] wdata = {d1_q, d2_q};
   wire wr_cfg = wr_done && cmd_q == cmd_port_pkg::WR_CONFIG_TWO;
   wire wr_addr = wr_done && cmd_q == cmd_port_pkg::WR_NODE_ADDRESS;
   wire wr_cal = wr_done && cmd_q == cmd_port_pkg::WR_CURRENT_CAL;

   // ------------------------------------------------------------
   // read reply
   // ------------------------------------------------------------
   // R15 revision readout
   wire [13:0] rd_value =
      rx_cmd == cmd_port_pkg::RD_FIRMWARE ? FIRMWARE_REV :
      rx_cmd == cmd_port_pkg::RD_BOARD ? BOARD_REV : cfg_q;
   // R3 read reply start
   wire rd_go = rx_data && st_q == cmd_port_pkg::R_CMD && is_read &&
                !tx_busy && !boot_q;
   wire [6:0] rd_hi = rd_value[13:7];
   wire [6:0] rd_lo = rd_value[6:0];
   // R4 reply checksum
   wire [6:0] rd_sum = 7'(rd_hi + rd_lo + rx_cmd);

   // ------------------------------------------------------------
   // calibration plausibility
   // ------------------------------------------------------------
   wire [13:0] cal_diff = wdata > measured_current ?
                          wdata - measured_current :
                          measured_current - wdata;
   // R14 twenty percent window
   wire [16:0] diff_scaled = 17'(cal_diff) * cmd_port_pkg::CAL_TOL_DIV;
   wire cal_ok = diff_scaled <= 17'(measured_current);

   // ------------------------------------------------------------
   // receive sequencer
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // R18 marked byte restarts
      if (rx_start) begin
         // R5 own address only
         st_d = addr_hit ? cmd_port_pkg::R_CMD : cmd_port_pkg::R_IDLE;
      end else if (rx_data) begin
         unique case (st_q)
            cmd_port_pkg::R_IDLE: begin
               st_d = cmd_port_pkg::R_IDLE;
            end
            // R1 write frame order
            cmd_port_pkg::R_CMD: begin
               st_d = is_write ? cmd_port_pkg::R_D1 : cmd_port_pkg::R_IDLE;
            end
            cmd_port_pkg::R_D1: begin
               st_d = cmd_port_pkg::R_D2;
            end
            cmd_port_pkg::R_D2: begin
               st_d = cmd_port_pkg::R_SUM;
            end
            cmd_port_pkg::R_SUM: begin
               st_d = cmd_port_pkg::R_IDLE;
            end
            default: begin
               st_d = cmd_port_pkg::R_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= cmd_port_pkg::R_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cmd_q <= 7'h00;
         d1_q <= 7'h00;
         d2_q <= 7'h00;
      end else if (rx_data) begin
         if (st_q == cmd_port_pkg::R_CMD) begin
            cmd_q <= rx_byte[6:0];
         end
         if (st_q == cmd_port_pkg::R_D1) begin
            d1_q <= rx_byte[6:0];
         end
         if (st_q == cmd_port_pkg::R_D2) begin
            d2_q <= rx_byte[6:0];
         end
      end
   end

   // ------------------------------------------------------------
   // node address and boot
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         boot_q <= 1'b1;
         addr_q <= cmd_port_pkg::NODE_ADDRESS_RESET;
         nv_wr_q <= 1'b0;
      end else begin
         boot_q <= 1'b0;
         nv_wr_q <= wr_addr;
         // R7 restore stored address
         if (boot_q) begin
            addr_q <= nv_addr_in;
         // R6 address from low byte
         end else if (wr_addr) begin
            addr_q <= d2_q;
         end
      end
   end

   // ------------------------------------------------------------
   // configuration two and calibration
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         // R9 baud resets to 19200
         cfg_q <= cmd_port_pkg::CONFIG_TWO_RESET;
      // R16 write one clears
      end else if (wr_cfg) begin
         cfg_q <= cfg_q & ~wdata;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cal_pend_q <= cmd_port_pkg::CAL_RESET;
         cal_q <= cmd_port_pkg::CAL_RESET;
      end else begin
         // R14 discard implausible value
         if (wr_cal && cal_ok) begin
            cal_pend_q <= wdata;
         end
         // R13 applied on save
         if (save_cal) begin
            cal_q <= cal_pend_q;
         end
      end
   end

   // ------------------------------------------------------------
   // transmit
   // ------------------------------------------------------------
   wire tx_take = tx_valid_q && tx_ready;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tx_valid_q <= 1'b0;
         tx_byte_q <= 8'h00;
         tx_buf_q <= 16'h0000;
         tx_cnt_q <= 2'h0;
      // R8 announce address at start
      end else if (boot_q) begin
         tx_valid_q <= 1'b1;
         tx_byte_q <= {1'b0, nv_addr_in};
         tx_cnt_q <= cmd_port_pkg::START_BYTES;
      end else if (rd_go) begin
         tx_valid_q <= 1'b1;
         tx_byte_q <= {1'b0, rd_hi};
         tx_buf_q <= {1'b0, rd_lo, 1'b0, rd_sum};
         tx_cnt_q <= cmd_port_pkg::REPLY_BYTES;
      end else if (tx_take) begin
         tx_valid_q <= tx_cnt_q > 2'h1;
         tx_byte_q <= tx_buf_q[15:8];
         tx_buf_q <= {tx_buf_q[7:0], 8'h00};
         tx_cnt_q <= tx_cnt_q - 2'h1;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign tx_valid = tx_valid_q;
   assign tx_byte = tx_byte_q;
   assign nv_addr_wr = nv_wr_q;
   assign node_addr = addr_q;
   assign cal_value = cal_q;
   // R10 compensation enable
   assign comp_enable = cfg_q[cmd_port_pkg::CFG_TOP_COMP_BIT];
   // R11 brake input as logic input
   assign brake_ignore = cfg_q[cmd_port_pkg::CFG_BRAKE_IGN_BIT];
   // R12 pulse resolution
   assign pulse_resolution_select = cfg_q[cmd_port_pkg::CFG_PULSE_RES_BIT];
   // R9 baud field
   assign baud_select =
      cfg_q[cmd_port_pkg::CFG_BAUD_MSB:cmd_port_pkg::CFG_BAUD_LSB];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   a_start_announce: assert property ( // R8
      boot_q |=> tx_valid && tx_byte == {1'b0, node_addr} && !boot_q)
      else $error("node address not sent at start");

   a_addr_filter: assert property ( // R5
      rx_start && !addr_hit |=> st_q == cmd_port_pkg::R_IDLE)
      else $error("foreign frame not ignored");

   a_frame_restart: assert property ( // R18
      rx_start && addr_hit |=> st_q == cmd_port_pkg::R_CMD)
      else $error("marked byte did not start frame");

   a_bad_sum_drop: assert property ( // R17
      rx_data && st_q == cmd_port_pkg::R_SUM && !sum_ok
      |=> $stable(cfg_q) && $stable(addr_q) && $stable(cal_pend_q))
      else $error("bad checksum frame changed state");

   a_reply_sum: assert property ( // R4
      rd_go |=> tx_valid && tx_buf_q[6:0] ==
      7'(tx_byte[6:0] + tx_buf_q[14:8] + $past(rx_byte[6:0])))
      else $error("reply checksum wrong");

   a_reply_bytes: assert property ( // R3
      rd_go ##1 tx_ready [*3] |-> ##1 !tx_valid)
      else $error("read reply not three bytes");

   a_addr_write: assert property ( // R6
      wr_addr |=> node_addr == $past(d2_q) && nv_addr_wr ##1 !nv_addr_wr)
      else $error("address write wrong");

   a_clear_bits: assert property ( // R16
      wr_cfg |=> cfg_q == ($past(cfg_q) & ~$past(wdata)))
      else $error("config write not one-to-clear");

   a_cal_reject: assert property ( // R14
      wr_cal && !cal_ok |=> $stable(cal_pend_q))
      else $error("implausible calibration accepted");

   a_cal_save: assert property ( // R13
      wr_cal && cal_ok ##1 save_cal |=> cal_value == $past(wdata, 2))
      else $error("saved calibration not applied");

   a_revision: assert property ( // R15
      rd_go && rx_cmd == cmd_port_pkg::RD_BOARD |=> tx_byte[6:0] ==
      BOARD_REV[13:7])
      else $error("board revision wrong");

   a_tx_bit_clear: assert property ( // R3
      tx_valid |-> !tx_byte[7])
      else $error("sent byte has top bit set");

   a_tx_hold_byte: assert property ( // R3
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("offered byte changed before taken");

   a_write_silent: assert property ( // R3
      wr_done && !tx_busy |=> !tx_valid)
      else $error("write frame answered");

   a_bad_sum_silent: assert property ( // R17
      rx_data && st_q == cmd_port_pkg::R_SUM && !sum_ok && !tx_busy
      |=> !tx_valid)
      else $error("bad checksum frame answered");

   a_boot_restore: assert property ( // R7
      boot_q |=> node_addr == $past(nv_addr_in))
      else $error("stored address not restored");

   a_boot_once: assert property ( // R8
      !boot_q |=> !boot_q)
      else $error("start announce repeated");

   a_addr_only_write: assert property ( // R6
      !wr_addr && !boot_q |=> $stable(node_addr))
      else $error("node address changed without write");

   a_cfg_only_write: assert property ( // R16
      !wr_cfg |=> $stable(cfg_q))
      else $error("config two changed without write");

   a_cal_accept: assert property ( // R13
      wr_cal && cal_ok |=> cal_pend_q == $past(wdata))
      else $error("plausible calibration not taken");

   a_cal_only_save: assert property ( // R13
      !save_cal |=> $stable(cal_value))
      else $error("calibration applied without save");
endmodule

// >>> verif/host_model.sv
// Purpose: host on the shared serial line, byte level
// Assumes: bytes are handed over at the falling edge
// Notes: slow makes tx_ready stall every other cycle
`timescale 1ns/100ps
module host_model (
   input wire logic mclk,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready
);
   logic slow;
   logic [7:0] got[$];
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b1;
      slow = 1'b0;
   end
   always @(negedge mclk) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end
   always @(posedge mclk) begin
      if (tx_valid && tx_ready) begin
         got.push_back(tx_byte);
      end
   end
   task automatic put(input logic [7:0] b);
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_byte = b;
   endtask
   task automatic frame(input logic [6:0] a, input logic [6:0] c,
         input logic [13:0] v, input logic wr, input logic bad);
      logic [6:0] s;
      s = c + v[13:7] + v[6:0] + {6'h00, bad};
      put({1'b1, a});
      put({1'b0, c});
      if (wr) begin
         put({1'b0, v[13:7]});
         put({1'b0, v[6:0]});
         put({1'b0, s});
      end
      @(negedge mclk);
      rx_valid = 1'b0;
      rx_byte = ~rx_byte;
   endtask
endmodule

// >>> verif/uart_register_command_port_tb_top.sv
// Purpose: self-checking bench of the serial command port
// Assumes: start address 0x05 held in the non-volatile store
// Notes: revision values are arbitrary
`timescale 1ns/100ps
module uart_register_command_port_tb_top;
   localparam logic [13:0] FW = 14'h1a5c;
   localparam logic [13:0] BW = 14'h0b3f;
   logic mclk, nrst, rx_valid, tx_valid, tx_ready, nv_addr_wr, save_cal;
   logic comp_enable, brake_ignore, pulse_resolution_select;
   logic [7:0] rx_byte, tx_byte;
   logic [6:0] nv_addr_in, node_addr;
   logic [13:0] measured_current, cal_value;
   logic [1:0] baud_select;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;
   int nv_pulses = 0;
   cmd_port #(.FIRMWARE_REV(FW), .BOARD_REV(BW)) cmd_port_inst (
      .mclk(mclk), .nrst(nrst), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
      .nv_addr_in(nv_addr_in), .nv_addr_wr(nv_addr_wr),
      .node_addr(node_addr), .measured_current(measured_current),
      .save_cal(save_cal), .cal_value(cal_value),
      .comp_enable(comp_enable), .brake_ignore(brake_ignore),
      .pulse_resolution_select(pulse_resolution_select),
      .baud_select(baud_select));
   host_model host_model_inst (.mclk(mclk), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_ready(tx_ready));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (nv_addr_wr === 1'b1) nv_pulses++;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [13:0] g, input logic [13:0] e,
         input string m);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic cfg(input logic [13:0] e);
      chk({5'h00, comp_enable, brake_ignore, pulse_resolution_select,
         3'h0, baud_select, 1'b0}, e, "config outputs");
   endtask
   task automatic rd(input logic [6:0] a, input logic [6:0] c,
         input logic [13:0] v, input logic ans);
      logic [6:0] s;
      s = v[13:7] + v[6:0] + c;
      host_model_inst.got.delete();
      host_model_inst.frame(a, c, 14'h0000, 1'b0, 1'b0);
      repeat (12) @(negedge mclk);
      chk(14'(host_model_inst.got.size()), ans ? 14'h3 : 14'h0,
         "count");
      if (ans && host_model_inst.got.size() == 3) begin
         chk({host_model_inst.got[0][6:0], host_model_inst.got[1][6:0]},
            v, "reply value");
         chk({6'h00, host_model_inst.got[2]}, {7'h00, s}, "sum");
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [6:0] c,
         input logic [13:0] v, input logic bad);
      host_model_inst.frame(a, c, v, 1'b1, bad);
      repeat (2) @(negedge mclk);
   endtask
   task automatic save();
      @(negedge mclk);
      save_cal = 1'b1;
      @(negedge mclk);
      save_cal = 1'b0;
      @(negedge mclk);
   endtask
   task automatic t_boot();
      repeat (4) @(negedge mclk);
      chk(14'(host_model_inst.got.size()), 14'h1, "start count");
      chk({6'h00, host_model_inst.got[0]}, 14'h0005, "start");
      chk({7'h00, node_addr}, 14'h0005, "restored address");
      cfg(14'h0100);
   endtask
   task automatic t_reads();
      host_model_inst.slow = 1'b1;
      rd(7'h05, cmd_port_pkg::RD_FIRMWARE, FW, 1'b1);
      rd(7'h05, cmd_port_pkg::RD_BOARD, BW, 1'b1);
      rd(7'h05, cmd_port_pkg::RD_CONFIG_TWO, 14'h0100, 1'b1);
      rd(7'h05, cmd_port_pkg::WR_NODE_ADDRESS, 14'h0000, 1'b0);
      rd(7'h06, cmd_port_pkg::RD_FIRMWARE, FW, 1'b0);
      host_model_inst.slow = 1'b0;
   endtask
   task automatic t_cfg();
      wr(7'h06, cmd_port_pkg::WR_CONFIG_TWO, 14'h0100, 1'b0);
      cfg(14'h0100);
      wr(7'h05, cmd_port_pkg::WR_CONFIG_TWO, 14'h0100, 1'b1);
      cfg(14'h0100);
      wr(7'h05, cmd_port_pkg::WR_CONFIG_TWO, 14'h0000, 1'b0);
      cfg(14'h0100);
      wr(7'h05, cmd_port_pkg::WR_CONFIG_TWO, 14'h01c6, 1'b0);
      cfg(14'h0000);
      rd(7'h05, cmd_port_pkg::RD_CONFIG_TWO, 14'h0000, 1'b1);
   endtask
   task automatic t_addr();
      host_model_inst.put(8'h85);
      host_model_inst.put({1'b0, cmd_port_pkg::WR_NODE_ADDRESS});
      wr(7'h05, cmd_port_pkg::WR_NODE_ADDRESS, 14'h3f92, 1'b0);
      chk({7'h00, node_addr}, 14'h0012, "new address");
      chk(14'(nv_pulses), 14'h1, "store pulses");
      rd(7'h05, cmd_port_pkg::RD_FIRMWARE, FW, 1'b0);
      rd(7'h12, cmd_port_pkg::RD_BOARD, BW, 1'b1);
   endtask
   task automatic t_cal();
      measured_current = 14'd100;
      wr(7'h12, cmd_port_pkg::WR_CURRENT_CAL, 14'd120, 1'b0);
      chk(cal_value, 14'h0000, "cal before save");
      save();
      chk(cal_value, 14'd120, "cal upper edge");
      wr(7'h12, cmd_port_pkg::WR_CURRENT_CAL, 14'd121, 1'b0);
      wr(7'h12, cmd_port_pkg::WR_CURRENT_CAL, 14'd79, 1'b0);
      save();
      chk(cal_value, 14'd120, "cal out of range");
      wr(7'h12, cmd_port_pkg::WR_CURRENT_CAL, 14'd80, 1'b0);
      save();
      chk(cal_value, 14'd80, "cal lower edge");
      // save strobe right in the cycle after the checksum byte
      host_model_inst.frame(7'h12, cmd_port_pkg::WR_CURRENT_CAL, 14'd100,
         1'b1, 1'b0);
      save_cal = 1'b1;
      @(negedge mclk);
      save_cal = 1'b0;
      @(negedge mclk);
      chk(cal_value, 14'd100, "cal saved at once");
   endtask
   initial begin
      nrst = 1'b0;
      nv_addr_in = 7'h05;
      measured_current = 14'h0000;
      save_cal = 1'b0;
      repeat (8) @(negedge mclk);
      nrst = 1'b1;
      t_boot();
      t_reads();
      t_cfg();
      t_addr();
      t_cal();
      results();
   end
endmodule
